// ==== rtl/bsub_alu.sv ====
/*
 Combinational 8-bit subtractor a - b - borrow_in with status flags.
 Assumes operands come from registers on the same clock.
*/
`timescale 1ns/100ps
`include "bsub_map.svh"
module bsub_alu
(
	// Operands
	input  wire logic [7:0] a,
	input  wire logic [7:0] b,
	input  wire logic       borrow_in,
	// Results
	output logic      [7:0] diff,
	output logic      [4:0] flags
);
	logic [8:0] full;
	logic [4:0] lo;
	always_comb
	begin
		full  = {1'b0, a} + {1'b0, ~b} + {8'h00, ~borrow_in};
		lo    = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, ~borrow_in};
		diff  = full[7:0];
		flags = 5'h00;
		flags[`BSUB_FLAG_C]  = full[8];
		flags[`BSUB_FLAG_DC] = lo[4];
		flags[`BSUB_FLAG_Z]  = (full[7:0] == 8'h00);
		flags[`BSUB_FLAG_OV] = (a[7] != b[7]) && (full[7] != a[7]);
		flags[`BSUB_FLAG_N]  = full[7];
	end
endmodule

// ==== rtl/bsub_core.sv ====
/*
 Byte subtract execution unit: literal, file and file-with-borrow subtracts,
 run in four phases, with an APB slave for control and state.
 Assumes the data memory answers a read with rdata in the phase after the
 address is shown, and the APB master holds each transfer until pready.
*/
//Overview of operation
//- Literal subtract 0000 1000 kkkk kkkk puts literal minus W into W
//- File subtract 0101 11da ffff ffff computes file minus W, two's complement
//- Destination bit 0 writes W; bit 1 writes back the file register
//- Access bit 0 resolves the file address inside the access bank
//- Access bit 1 uses the bank select register to pick the bank
//- Extended set, access bit 0, address up to 5Fh: indexed literal offset
`timescale 1ns/100ps
`include "bsub_map.svh"
module bsub_core
(
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    rst,
	// APB slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [11:0]             paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	// Data memory
	output logic      [`BSUB_ADDR_W-1:0] mem_addr,
	output logic                         mem_rd,
	output logic                         mem_wr,
	output logic      [7:0]              mem_wdata,
	input  wire logic [7:0]              mem_rdata,
	// Indexed literal offset request and busy flag
	output logic                         idx_mode,
	output logic                         busy
);
	bsub_pkg::bsub_kind_e  kind_reg, kind_next;
	bsub_pkg::bsub_phase_e ph_reg, ph_next;
	logic [15:0] instr_reg, instr_next;
	logic [7:0]  wreg_reg, wreg_next, opa_reg, opa_next, opb_reg, opb_next;
	logic [7:0]  res_reg, res_next;
	logic [4:0]  st_reg, st_next;
	logic [`BSUB_BANK_W-1:0] bsr_reg, bsr_next;
	logic        ext_reg, ext_next, done_reg, done_next;
	logic [`BSUB_ADDR_W-1:0] addr_reg, addr_next;
	logic [7:0]  diff;
	logic [4:0]  flags;
	logic        acc, dst, wr_en, rd_en, go;
	logic [7:0]  fadr;
	bsub_alu u_alu
	(
		.a         (opa_reg),
		.b         (opb_reg),
		.borrow_in (kind_reg == bsub_pkg::BSUB_FWB ? ~st_reg[`BSUB_FLAG_C] : 1'b0),
		.diff      (diff),
		.flags     (flags)
	);
	assign acc     = instr_reg[8];
	assign dst     = instr_reg[9];
	assign fadr    = instr_reg[7:0];
	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && penable && !pwrite;
	assign go      = wr_en && (paddr == `BSUB_APB_INSTR) && (ph_reg == bsub_pkg::BSUB_Q1)
		&& (kind_reg == bsub_pkg::BSUB_NONE);
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign busy    = (kind_reg != bsub_pkg::BSUB_NONE);
	always_comb
	begin
		kind_next  = kind_reg;
		ph_next    = ph_reg;
		instr_next = instr_reg;
		wreg_next  = wreg_reg;
		opa_next   = opa_reg;
		opb_next   = opb_reg;
		res_next   = res_reg;
		st_next    = st_reg;
		bsr_next   = bsr_reg;
		ext_next   = ext_reg;
		addr_next  = addr_reg;
		done_next  = done_reg;
		mem_rd     = 1'b0;
		mem_wr     = 1'b0;
		idx_mode   = 1'b0;
		if (wr_en && paddr == `BSUB_APB_CTRL)
			ext_next = pwdata[0];
		if (wr_en && paddr == `BSUB_APB_BSR)
			bsr_next = pwdata[`BSUB_BANK_W-1:0];
		if (wr_en && paddr == `BSUB_APB_WREG && !busy)
			wreg_next = pwdata[7:0];
		if (wr_en && paddr == `BSUB_APB_STATUS && !busy)
			st_next = pwdata[4:0];
		if (go)
		begin
			instr_next = pwdata[15:0];
			done_next  = 1'b0;
			ph_next    = bsub_pkg::BSUB_Q2;
			if (pwdata[15:8] == `BSUB_OP_LIT_HI)
				kind_next = bsub_pkg::BSUB_LIT;
			else if (pwdata[15:10] == `BSUB_OP_FILE_HI6)
				kind_next = bsub_pkg::BSUB_FILE;
			else if (pwdata[15:10] == `BSUB_OP_FWB_HI6)
				kind_next = bsub_pkg::BSUB_FWB;
			else
				ph_next = bsub_pkg::BSUB_Q1;
			// Address resolution done at decode
			if (pwdata[8] == `BSUB_ADDR_BANKED)
				addr_next = {bsr_reg, pwdata[7:0]};
			else if (pwdata[7])
				addr_next = {`BSUB_ACC_HI_BANK, pwdata[7:0]};
			else
				addr_next = {4'h0, pwdata[7:0]};
		end
		case (ph_reg)
			bsub_pkg::BSUB_Q1:
			begin
			end
			bsub_pkg::BSUB_Q2:
			begin
				// Operand fetch
				mem_rd   = (kind_reg != bsub_pkg::BSUB_LIT);
				idx_mode = mem_rd && ext_reg && !acc && (fadr <= `BSUB_IDX_LIMIT);
				ph_next  = bsub_pkg::BSUB_Q3;
			end
			bsub_pkg::BSUB_Q3:
			begin
				case (kind_reg)
					bsub_pkg::BSUB_LIT:
					begin
						opa_next = fadr;
						opb_next = wreg_reg;
					end
					bsub_pkg::BSUB_FILE:
					begin
						opa_next = mem_rdata;
						opb_next = wreg_reg;
					end
					default:
					begin
						opa_next = wreg_reg;
						opb_next = mem_rdata;
					end
				endcase
				ph_next = bsub_pkg::BSUB_Q4;
			end
			bsub_pkg::BSUB_Q4:
			begin
				res_next  = diff;
				st_next   = flags;
				done_next = 1'b1;
				if (kind_reg == bsub_pkg::BSUB_LIT || !dst)
					wreg_next = diff;
				else
					mem_wr = 1'b1;
				kind_next = bsub_pkg::BSUB_NONE;
				ph_next   = bsub_pkg::BSUB_Q1;
			end
			default:
				ph_next = bsub_pkg::BSUB_Q1;
		endcase
	end
	assign mem_addr  = addr_reg;
	assign mem_wdata = diff;
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			kind_reg  <= bsub_pkg::BSUB_NONE;
			ph_reg    <= bsub_pkg::BSUB_Q1;
			instr_reg <= 16'h0000;
			wreg_reg  <= `BSUB_WREG_RST;
			opa_reg   <= 8'h00;
			opb_reg   <= 8'h00;
			res_reg   <= 8'h00;
			st_reg    <= `BSUB_STATUS_RST;
			bsr_reg   <= 4'h0;
			ext_reg   <= 1'b0;
			addr_reg  <= 12'h000;
			done_reg  <= 1'b0;
		end
		else
		begin
			kind_reg  <= kind_next;
			ph_reg    <= ph_next;
			instr_reg <= instr_next;
			wreg_reg  <= wreg_next;
			opa_reg   <= opa_next;
			opb_reg   <= opb_next;
			res_reg   <= res_next;
			st_reg    <= st_next;
			bsr_reg   <= bsr_next;
			ext_reg   <= ext_next;
			addr_reg  <= addr_next;
			done_reg  <= done_next;
		end
	end
	always_comb
	begin
		prdata = 32'h00000000;
		if (rd_en)
		begin
			case (paddr)
				`BSUB_APB_CTRL:   prdata = {31'h00000000, ext_reg};
				`BSUB_APB_BSR:    prdata = {28'h0000000, bsr_reg};
				`BSUB_APB_WREG:   prdata = {24'h000000, wreg_reg};
				`BSUB_APB_STATUS: prdata = {22'h000000, done_reg, busy, 3'h0, st_reg};
				`BSUB_APB_INSTR:  prdata = {16'h0000, instr_reg};
				`BSUB_APB_RESULT: prdata = {24'h000000, res_reg};
				default:          prdata = 32'h00000000;
			endcase
		end
	end
	AST_LIT_RESULT: assert property (@(posedge clk) disable iff (rst)
		(ph_reg == bsub_pkg::BSUB_Q4 && kind_reg == bsub_pkg::BSUB_LIT)
		|=> wreg_reg == $past(opa_reg) - $past(opb_reg))
		else $error("literal subtract result wrong");
	AST_FILE_ORDER: assert property (@(posedge clk) disable iff (rst)
		(ph_reg == bsub_pkg::BSUB_Q4 && kind_reg == bsub_pkg::BSUB_FILE)
		|-> diff == opa_reg - opb_reg && opa_reg == $past(mem_rdata) && opb_reg == wreg_reg)
		else $error("file subtract operand order wrong");
	AST_DEST_FILE: assert property (@(posedge clk) disable iff (rst)
		(ph_reg == bsub_pkg::BSUB_Q4 && kind_reg != bsub_pkg::BSUB_LIT && dst)
		|-> mem_wr && $stable(wreg_reg))
		else $error("file destination not written");
	AST_DEST_W: assert property (@(posedge clk) disable iff (rst)
		(ph_reg == bsub_pkg::BSUB_Q4 && kind_reg != bsub_pkg::BSUB_LIT && !dst)
		|-> !mem_wr ##1 wreg_reg == res_reg)
		else $error("W destination not written");
	AST_ACCESS: assert property (@(posedge clk) disable iff (rst)
		go && pwdata[8] == 1'b0 |=> addr_reg[7:0] == $past(pwdata[7:0])
		&& addr_reg[11:8] == ($past(pwdata[7]) ? 4'hF : 4'h0))
		else $error("access bank address wrong");
	AST_BANKED: assert property (@(posedge clk) disable iff (rst)
		go && pwdata[8] |=> addr_reg[11:8] == $past(bsr_reg))
		else $error("banked address ignores bank select");
	AST_INDEXED: assert property (@(posedge clk) disable iff (rst)
		(mem_rd || idx_mode) |-> mem_rd
		&& idx_mode == (ext_reg && !acc && fadr <= `BSUB_IDX_LIMIT))
		else $error("indexed mode conditions wrong");
	AST_FLAGS: assert property (@(posedge clk) disable iff (rst)
		ph_reg == bsub_pkg::BSUB_Q4 |=> st_reg[2] == (res_reg == 8'h00)
		&& st_reg[4] == res_reg[7])
		else $error("zero or negative flag wrong");
	AST_SEQ: assert property (@(posedge clk) disable iff (rst)
		go && kind_next != bsub_pkg::BSUB_NONE |=> ##2 ph_reg == bsub_pkg::BSUB_Q4 ##1 !busy)
		else $error("instruction did not finish in four phases");
	COV_LIT: cover property (@(posedge clk) ph_reg == bsub_pkg::BSUB_Q4
		&& kind_reg == bsub_pkg::BSUB_LIT);
	COV_FILE_WB: cover property (@(posedge clk) mem_wr);
	COV_FWB: cover property (@(posedge clk) ph_reg == bsub_pkg::BSUB_Q4
		&& kind_reg == bsub_pkg::BSUB_FWB);
	COV_IDX: cover property (@(posedge clk) idx_mode);
endmodule

// ==== rtl/bsub_map.svh ====
/*
 Timing counts, opcode fields and flag positions of the byte subtract unit.
 Assumes it is included by its bare name from the modules.
*/
`ifndef BSUB_MAP_SVH
`define BSUB_MAP_SVH
`define BSUB_OP_LIT_HI     8'h08
`define BSUB_OP_FILE_HI6   6'h17
`define BSUB_OP_FWB_HI6    6'h15
`define BSUB_IDX_LIMIT     8'h5F
`define BSUB_PHASES        2'h3
`define BSUB_FLAG_C        0
`define BSUB_FLAG_DC       1
`define BSUB_FLAG_Z        2
`define BSUB_FLAG_OV       3
`define BSUB_FLAG_N        4
`define BSUB_ADDR_ACCESS   1'h0
`define BSUB_ADDR_BANKED   1'h1
`define BSUB_STATUS_RST    5'h00
`define BSUB_WREG_RST      8'h00
`define BSUB_ADDR_W        12
`define BSUB_BANK_W        4
`define BSUB_ACC_HI_BANK   4'hF
`define BSUB_APB_CTRL      12'h000
`define BSUB_APB_BSR       12'h004
`define BSUB_APB_WREG      12'h008
`define BSUB_APB_STATUS    12'h00C
`define BSUB_APB_INSTR     12'h010
`define BSUB_APB_RESULT    12'h014
`endif

// ==== rtl/bsub_pkg.sv ====
/*
 Types of the byte subtract unit: instruction kind and phase.
 Assumes nothing outside it.
*/
package bsub_pkg;
	typedef enum logic [1:0] {
		BSUB_NONE,
		BSUB_LIT,
		BSUB_FILE,
		BSUB_FWB
	} bsub_kind_e;
	typedef enum logic [1:0] {
		BSUB_Q1,
		BSUB_Q2,
		BSUB_Q3,
		BSUB_Q4
	} bsub_phase_e;
endpackage

// ==== sim/tb_top.sv ====
/*
 Self-checking bench of the byte subtract unit: random and corner subtracts.
 Assumes the core answers APB with zero wait states and reads memory in Q2.
*/
`timescale 1ns/100ps
`include "bsub_map.svh"
module tb_top;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic        pready;
	logic        pslverr;
	logic        mem_rd;
	logic        mem_wr;
	logic        idx_mode;
	logic        busy;
	logic        cap_idx;
	logic [11:0] mem_addr;
	logic [11:0] cap_addr;
	logic [7:0]  mem_wdata;
	logic [7:0]  mem_rdata = 8'h00;
	logic [7:0]  mem [4096];
	int          fails = 0;
	int          cmp_count = 0;

	always #25 clk = ~clk;

	bsub_core i_dut
	(
		.clk       (clk),
		.rst       (rst),
		.psel      (psel),
		.penable   (penable),
		.pwrite    (pwrite),
		.paddr     (paddr),
		.pwdata    (pwdata),
		.prdata    (prdata),
		.pready    (pready),
		.pslverr   (pslverr),
		.mem_addr  (mem_addr),
		.mem_rd    (mem_rd),
		.mem_wr    (mem_wr),
		.mem_wdata (mem_wdata),
		.mem_rdata (mem_rdata),
		.idx_mode  (idx_mode),
		.busy      (busy)
	);

	// Data memory: answers in the cycle after the read, else shows a moving pattern
	always @(posedge clk)
	begin
		if (mem_rd)
		begin
			mem_rdata <= mem[mem_addr];
			cap_addr  <= mem_addr;
			cap_idx   <= idx_mode;
		end
		else
			mem_rdata <= ~mem_rdata;
		if (mem_wr)
			mem[mem_addr] <= mem_wdata;
	end

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// One APB transfer, entered just after a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (n = 0; n < 10; n++)
		begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		if (n >= 10)
		begin
			fails++;
			end_sim();
		end
		rd = prdata;
		chk(pslverr, 32'h0, "pslverr");
		psel    <= 1'b0;
		penable <= 1'b0;
		// One idle edge, so that back-to-back calls never drive psel twice in one step
		@(posedge clk);
	endtask

	// Expected {no borrow, result}
	function automatic logic [8:0] exp_sub(int kind, int x, int w, int c);
		int r;
		r = (kind == 2) ? w - x - (1 - c) : x - w;
		return {r >= 0, r[7:0]};
	endfunction

	// Expected {overflow, no borrow from the low nibble}
	function automatic logic [1:0] exp_dcov(int kind, int x, int w, int c);
		int p, q, b, lo, s;
		p  = (kind == 2) ? w : x;
		q  = (kind == 2) ? x : w;
		b  = (kind == 2) ? 1 - c : 0;
		lo = (p % 16) - (q % 16) - b;
		s  = ((p > 127) ? p - 256 : p) - ((q > 127) ? q - 256 : q) - b;
		return {s < -128 || s > 127, lo >= 0};
	endfunction

	initial
	begin
		int          kind, w, f, v, c, ext, bank_select_register, d, a, n;
		logic [8:0]  r;
		logic [1:0]  dv;
		logic [11:0] ea;
		logic [15:0] op;
		void'($urandom(34369));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, `BSUB_APB_WREG, 32'h0);
		chk(rd, 32'h0, "reset wreg");
		apb(1'b0, `BSUB_APB_STATUS, 32'h0);
		chk(rd & 32'h1F, 32'h0, "reset status");
		apb(1'b1, 12'h020, 32'hFFFFFFFF);
		apb(1'b0, 12'h020, 32'h0);
		chk(rd, 32'h0, "unmapped read");
		for (int t = 0; t < 60; t++)
		begin
			kind = $urandom_range(2);
			w    = $urandom_range(255);
			f    = $urandom_range(255);
			v    = $urandom_range(255);
			c    = $urandom_range(1);
			ext  = $urandom_range(1);
			bank_select_register  = $urandom_range(15);
			d    = $urandom_range(1);
			a    = $urandom_range(1);
			if (t < 4)
			begin
				kind = (t == 2) ? 0 : 1;
				a    = 0;
				ext  = 1;
				f    = (t == 0) ? 8'h5F : (t == 1) ? 8'h60 : 8'h80;
				w    = f;
				v    = w;
			end
			if (t == 4)
			begin
				kind = 1;
				d    = 1;
			end
			ea = a ? {bank_select_register[3:0], f[7:0]} : {(f >= 8'h80) ? 4'hF : 4'h0, f[7:0]};
			op = (kind == 0) ? {8'h08, f[7:0]} :
				{(kind == 1) ? 6'h17 : 6'h15, d[0], a[0], f[7:0]};
			r  = exp_sub(kind, (kind == 0) ? f : v, w, c);
			dv = exp_dcov(kind, (kind == 0) ? f : v, w, c);
			mem[ea] = v[7:0];
			apb(1'b1, `BSUB_APB_CTRL, ext);
			apb(1'b1, `BSUB_APB_BSR, bank_select_register);
			apb(1'b1, `BSUB_APB_WREG, w);
			apb(1'b1, `BSUB_APB_STATUS, c);
			apb(1'b1, `BSUB_APB_INSTR, op);
			// Test 4 writes W while its file-destination subtract runs: refused
			if (t == 4)
				apb(1'b1, `BSUB_APB_WREG, ~w);
			else
			begin
				@(posedge clk);
				chk(busy, 1'b1, "busy");
			end
			for (n = 0; busy && n < 20; n++)
				@(posedge clk);
			if (busy !== 1'b0)
			begin
				fails++;
				end_sim();
			end
			apb(1'b0, `BSUB_APB_WREG, 32'h0);
			chk(rd, (kind == 0 || d == 0) ? r[7:0] : w, "wreg");
			chk(mem[ea], (kind != 0 && d == 1) ? r[7:0] : v, "file");
			apb(1'b0, `BSUB_APB_STATUS, 32'h0);
			chk(rd & 32'h1F, {r[7], dv[1], r[7:0] == 8'h00, dv[0], r[8]}, "flags");
			chk(rd & 32'h300, 32'h200, "done, not busy");
			apb(1'b0, `BSUB_APB_RESULT, 32'h0);
			chk(rd, r[7:0], "result");
			if (kind != 0)
			begin
				chk(cap_addr, ea, "address");
				chk(cap_idx, ext == 1 && a == 0 && f <= 95, "indexed");
			end
			$display("test %0d kind %0d done", t, kind);
		end
		apb(1'b1, `BSUB_APB_INSTR, 32'h0000FF00);
		chk(busy, 1'b0, "unknown opcode stays idle");
		end_sim();
	end
endmodule
